//--- design/sram_host_consts.svh
// Timing counts, widths and lane indices for the SRAM-compatible memory host
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH

`define CLK_PERIOD_NS        20
`define ADDR_SETUP_NS        10
`define ADDR_SETUP_CYC       (((`ADDR_SETUP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define PRECHARGE_NS         60
`define PRECHARGE_CYC        (((`PRECHARGE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define ACCESS_NS            60
`define ACCESS_CYC           (((`ACCESS_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define PAGE_ACCESS_NS       30
`define PAGE_ACCESS_CYC      (((`PAGE_ACCESS_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define ADDR_W               17
`define COL_W                2
`define DATA_W               16
`define CNT_W                4
`define LANE_LO              0
`define LANE_HI              1

`endif

//--- design/sram_host_pkg.sv
// Types for the SRAM-compatible memory host
package sram_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_DONE,
    ST_PRECHARGE
  } host_state_t;

endpackage

//--- design/lane_steer.sv
// Byte-lane select and data steering for 16-bit or byte-wide wiring
`timescale 1ns/1ps
`include "sram_host_consts.svh"

module lane_steer (
  input  wire logic                 byte_mode_in,
  input  wire logic [1:0]           byte_en_in,
  input  wire logic                 byte_addr_in,
  input  wire logic [`DATA_W-1:0]   wdata_in,
  output logic      [1:0]           lane_sel_out,
  output logic      [`DATA_W-1:0]   wdata_out
);

  wire [1:0] byte_sel_w;
  wire       hi_w;

  // In byte mode the lowest address bit picks one lane
  assign hi_w         = byte_addr_in;
  assign byte_sel_w   = hi_w ? 2'h2 : 2'h1;
  assign lane_sel_out = byte_mode_in ? byte_sel_w : byte_en_in;
  // Joined lanes: place the byte on both halves so either lane sees it
  assign wdata_out    = byte_mode_in ? {wdata_in[7:0], wdata_in[7:0]} : wdata_in;

endmodule

//--- design/sram_host_ctrl.sv
// Host controller driving an asynchronous SRAM-compatible nonvolatile memory
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
`include "sram_host_consts.svh"

module sram_host_ctrl
  import sram_host_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 req_valid_in,
  input  wire logic                 req_write_in,
  input  wire logic                 req_last_in,
  input  wire logic                 req_strict_in,
  input  wire logic                 byte_mode_in,
  input  wire logic [1:0]           req_byte_en_in,
  input  wire logic [`ADDR_W:0]     req_addr_in,
  input  wire logic [`DATA_W-1:0]   req_wdata_in,
  input  wire logic [`DATA_W-1:0]   mem_dq_in,
  output logic                      req_ready_out,
  output logic                      rsp_valid_out,
  output logic      [`DATA_W-1:0]   rsp_rdata_out,
  output logic      [`ADDR_W-1:0]   mem_addr_out,
  output logic      [`DATA_W-1:0]   mem_dq_out,
  output logic                      mem_dq_oe_out,
  output logic                      mem_enable_n_out,
  output logic                      mem_write_n_out,
  output logic                      mem_output_n_out,
  output logic                      upper_lane_select_n_out,
  output logic                      lower_lane_select_n_out
);

  // ************************************************************
  // Request decode
  // ************************************************************
  host_state_t              state_r, state_nxt;
  logic [`CNT_W-1:0]        cnt_r;
  logic [`ADDR_W-1:0]       addr_r;
  logic [`DATA_W-1:0]       wdata_r;
  logic [1:0]               lanes_r;
  logic                     write_r;
  logic                     last_r;
  logic                     strict_r;
  logic                     page_r;

  wire  [1:0]               lane_sel_w;
  wire  [`DATA_W-1:0]       wdata_w;
  wire  [`ADDR_W-1:0]       word_addr_w;
  wire  [`ADDR_W-`COL_W-1:0] row_new_w;
  wire  [`ADDR_W-`COL_W-1:0] row_cur_w;
  wire                      same_row_w;
  wire                      take_w;
  wire                      no_lane_w;
  wire                      cnt_zero_w;
  wire  [`CNT_W-1:0]        acc_cnt_w;

  lane_steer u_lane_steer (
    .byte_mode_in (byte_mode_in),
    .byte_en_in   (req_byte_en_in),
    .byte_addr_in (req_addr_in[0]),
    .wdata_in     (req_wdata_in),
    .lane_sel_out (lane_sel_w),
    .wdata_out    (wdata_w)
  );

  // Byte mode uses the low bit as lane pick; word address is the rest
  assign word_addr_w = byte_mode_in ? req_addr_in[`ADDR_W:1] : req_addr_in[`ADDR_W-1:0];
  assign row_new_w   = word_addr_w[`ADDR_W-1:`COL_W];
  assign row_cur_w   = addr_r[`ADDR_W-1:`COL_W];
  // A page continues only if req_addr_in, one cycle after the take, is in the row captured in addr_r; otherwise full access time, no precharge
  assign same_row_w  = page_r && (row_new_w == row_cur_w) && !strict_r;
  assign no_lane_w   = (lane_sel_w == 2'h0);
  assign cnt_zero_w  = (cnt_r == '0);
  // Page hits reuse the open row and need only the shorter column time
  assign acc_cnt_w   = same_row_w ? `CNT_W'(`PAGE_ACCESS_CYC) : `CNT_W'(`ACCESS_CYC);
  assign take_w      = req_valid_in && req_ready_out;

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:      if (take_w) state_nxt = ST_SETUP;
      ST_SETUP:     if (cnt_zero_w) state_nxt = ST_ACCESS;
      ST_ACCESS:    if (cnt_zero_w) state_nxt = ST_DONE;
      ST_DONE:      state_nxt = (last_r || strict_r) ? ST_PRECHARGE : ST_IDLE;
      ST_PRECHARGE: if (cnt_zero_w) state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else if (state_r == ST_IDLE && take_w) begin
      cnt_r <= `CNT_W'(`ADDR_SETUP_CYC) - `CNT_W'(1);
    end else if (state_r == ST_SETUP && cnt_zero_w) begin
      cnt_r <= acc_cnt_w - `CNT_W'(1);
    end else if (state_r == ST_DONE) begin
      cnt_r <= `CNT_W'(`PRECHARGE_CYC) - `CNT_W'(1);
    end else if (!cnt_zero_w) begin
      cnt_r <= cnt_r - `CNT_W'(1);
    end
  end

  // ************************************************************
  // Request capture
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_r   <= '0;
      wdata_r  <= '0;
      lanes_r  <= 2'h0;
      write_r  <= 1'b0;
      last_r   <= 1'b1;
      strict_r <= 1'b0;
    end else if (take_w) begin
      addr_r   <= word_addr_w;
      wdata_r  <= wdata_w;
      lanes_r  <= lane_sel_w;
      write_r  <= req_write_in && !no_lane_w;
      last_r   <= req_last_in;
      strict_r <= req_strict_in;
    end
  end

  // Row stays open only while enable is held low between accesses
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_r <= 1'b0;
    end else if (state_r == ST_DONE) begin
      page_r <= !(last_r || strict_r);
    end else if (state_r == ST_PRECHARGE) begin
      page_r <= 1'b0;
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  wire enable_n_nxt_w;
  wire write_n_nxt_w;
  wire oe_n_nxt_w;
  wire dq_oe_nxt_w;
  wire busy_w;
  wire [1:0] lanes_use_w;
  wire write_use_w;

  assign busy_w         = (state_nxt == ST_SETUP) || (state_nxt == ST_ACCESS);
  // At the taking edge the captured lanes are not yet in their registers
  assign lanes_use_w    = (state_r == ST_IDLE) ? lane_sel_w : lanes_r;
  assign write_use_w    = (state_r == ST_IDLE) ? (req_write_in && !no_lane_w) : write_r;
  // Enable stays low across page accesses except one cycle after the first, before page_r is set; address alone starts each one
  assign enable_n_nxt_w = !(busy_w || (state_nxt == ST_DONE) ||
                            (state_nxt == ST_IDLE && page_r));
  // Write strobe only inside the access window, never around reset
  assign write_n_nxt_w  = !((state_nxt == ST_ACCESS) && write_r);
  assign oe_n_nxt_w     = !((state_nxt == ST_ACCESS) && !write_r && lanes_r != 2'h0);
  assign dq_oe_nxt_w    = busy_w && write_use_w;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_enable_n_out        <= 1'b1;
      mem_write_n_out         <= 1'b1;
      mem_output_n_out        <= 1'b1;
      mem_dq_oe_out           <= 1'b0;
      upper_lane_select_n_out <= 1'b1;
      lower_lane_select_n_out <= 1'b1;
    end else begin
      mem_enable_n_out        <= enable_n_nxt_w;
      mem_write_n_out         <= write_n_nxt_w;
      mem_output_n_out        <= oe_n_nxt_w;
      mem_dq_oe_out           <= dq_oe_nxt_w;
      upper_lane_select_n_out <= !(busy_w && lanes_use_w[`LANE_HI]);
      lower_lane_select_n_out <= !(busy_w && lanes_use_w[`LANE_LO]);
    end
  end

  // Address moves with the enable edge, never while enable is already low for a standalone access
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_addr_out <= '0;
      mem_dq_out   <= '0;
    end else if (state_r == ST_IDLE && take_w) begin
      mem_addr_out <= word_addr_w;
      mem_dq_out   <= wdata_w;
    end
  end

  // ************************************************************
  // Handshake and read return
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      req_ready_out <= (state_nxt == ST_IDLE) && !(state_r == ST_IDLE && take_w);
      rsp_valid_out <= (state_r == ST_ACCESS) && cnt_zero_w;
      if (state_r == ST_ACCESS && cnt_zero_w && !write_r) begin
        // Unselected lanes read as zero since the memory leaves them floating
        rsp_rdata_out <= mem_dq_in & {{8{lanes_r[`LANE_HI]}}, {8{lanes_r[`LANE_LO]}}};
      end
    end
  end

endmodule

//--- tb/sram_mem_model.sv
// Behavioural memory on the far side of the host
`timescale 1ns/1ps
module sram_mem_model (
  input  wire logic [16:0] addr_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        enable_n_in,
  input  wire logic        write_n_in,
  input  wire logic        output_n_in,
  input  wire logic        upper_n_in,
  input  wire logic        lower_n_in,
  output logic      [15:0] dq_out
);
  // Row is addr[16:2], column addr[1:0]; a row opens whole
  logic [15:0] mem [0:131071] = '{default: 16'h0000};
  wire  [15:0] word = mem[addr_in];
  wire         rd = !enable_n_in && !output_n_in;
  // No pull-ups on dq, so an idle lane shows the inverse byte
  assign dq_out = {rd && !upper_n_in ? word[15:8] : ~word[15:8],
                   rd && !lower_n_in ? word[7:0] : ~word[7:0]};
  // Level write avoids racing the strobe edge against lane release
  always @* begin
    if (!write_n_in && !enable_n_in && !lower_n_in) mem[addr_in][7:0] = dq_in[7:0];
    if (!write_n_in && !enable_n_in && !upper_n_in) mem[addr_in][15:8] = dq_in[15:8];
  end
endmodule

//--- tb/sram_host_ctrl_properties.sv
// Port checks for the memory host
`timescale 1ns/1ps
`include "sram_host_consts.svh"
module sram_host_ctrl_properties (
  input wire logic               ref_clk_in,
  input wire logic               arst_n_in,
  input wire logic               req_valid_in,
  input wire logic               req_strict_in,
  input wire logic               byte_mode_in,
  input wire logic [`ADDR_W:0]   req_addr_in,
  input wire logic               req_ready_out,
  input wire logic               rsp_valid_out,
  input wire logic [`ADDR_W-1:0] mem_addr_out,
  input wire logic               mem_dq_oe_out,
  input wire logic               mem_enable_n_out,
  input wire logic               mem_write_n_out,
  input wire logic               mem_output_n_out,
  input wire logic               upper_lane_select_n_out,
  input wire logic               lower_lane_select_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire take = req_valid_in && req_ready_out;
  chk_write_gated: assert property (!mem_write_n_out |-> !mem_enable_n_out && mem_dq_oe_out)
    else $error("write strobe outside a write");
  chk_no_lane: assert property (upper_lane_select_n_out && lower_lane_select_n_out
    |-> mem_write_n_out && !mem_dq_oe_out) else $error("activity with no lane");
  chk_take_busy: assert property (take |=> !req_ready_out) else $error("ready while busy");
  chk_take_answer: assert property (take |-> ##[3:6] rsp_valid_out) else $error("no answer");
  chk_strobe_excl: assert property (!mem_output_n_out |-> mem_write_n_out && !mem_dq_oe_out)
    else $error("read overlaps write");
  chk_strict_toggle: assert property (take && req_strict_in
    |-> ##[3:6] rsp_valid_out ##1 mem_enable_n_out [*3]) else $error("no enable toggle");
  chk_row_map: assert property (take && !byte_mode_in
    |-> ##3 mem_addr_out == $past(req_addr_in[`ADDR_W-1:0], 3)) else $error("address wrong");
  chk_byte_lane: assert property (take && byte_mode_in |-> ##2
    upper_lane_select_n_out == !$past(req_addr_in[0], 2)
    && lower_lane_select_n_out == $past(req_addr_in[0], 2)) else $error("lane wrong");
endmodule
bind sram_host_ctrl sram_host_ctrl_properties sram_host_ctrl_properties_inst (.*);

//--- tb/sram_compatible_access_ctrl_tb.sv
// Self-checking bench for the memory host
`timescale 1ns/1ps
`include "sram_host_consts.svh"
module sram_compatible_access_ctrl_tb;
  typedef struct packed {
    logic        w, bm, st, la;
    logic [1:0]  be;
    logic [17:0] a;
    logic [15:0] d, e;
  } row_t;
  logic ref_clk_in, arst_n_in, req_valid_in, req_write_in, req_last_in, req_strict_in;
  logic byte_mode_in, req_ready_out, rsp_valid_out, mem_dq_oe_out, mem_enable_n_out;
  logic mem_write_n_out, mem_output_n_out, upper_lane_select_n_out, lower_lane_select_n_out;
  logic [1:0]         req_byte_en_in;
  logic [`ADDR_W:0]   req_addr_in;
  logic [`ADDR_W-1:0] mem_addr_out;
  logic [`DATA_W-1:0] req_wdata_in, mem_dq_in, rsp_rdata_out, mem_dq_out;
  int n_mismatch = 0;
  int num_checks = 0;
  int k;
  // Page hits, a row change, a lane-less write and a byte-wide write
  row_t rows [10] = '{
    '{1, 0, 0, 0, 2'h3, 18'h00004, 16'h1234, 16'h0000},
    '{1, 0, 0, 0, 2'h1, 18'h00005, 16'habcd, 16'h0000},
    '{1, 0, 0, 1, 2'h2, 18'h00006, 16'h5a5a, 16'h0000},
    '{0, 0, 0, 0, 2'h3, 18'h00004, 16'h0000, 16'h1234},
    '{0, 0, 0, 0, 2'h3, 18'h00005, 16'h0000, 16'h00cd},
    '{0, 0, 0, 1, 2'h2, 18'h00006, 16'h0000, 16'h5a00},
    '{1, 0, 1, 0, 2'h0, 18'h10008, 16'hffff, 16'h0000},
    '{0, 0, 1, 0, 2'h3, 18'h10008, 16'h0000, 16'h0000},
    '{1, 1, 0, 1, 2'h0, 18'h00021, 16'h0077, 16'h0000},
    '{0, 0, 0, 1, 2'h3, 18'h00010, 16'h0000, 16'h7700}};
  sram_host_ctrl sram_host_ctrl_inst (.*);
  sram_mem_model sram_mem_model_inst (.addr_in(mem_addr_out), .dq_in(mem_dq_out),
    .enable_n_in(mem_enable_n_out), .write_n_in(mem_write_n_out),
    .output_n_in(mem_output_n_out), .upper_n_in(upper_lane_select_n_out),
    .lower_n_in(lower_lane_select_n_out), .dq_out(mem_dq_in));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Request held until a rising edge sees ready high
  task automatic acc(input row_t r);
    {req_write_in, byte_mode_in, req_strict_in, req_last_in} = {r.w, r.bm, r.st, r.la};
    {req_byte_en_in, req_addr_in, req_wdata_in} = {r.be, r.a, r.d};
    req_valid_in = 1'b1;
    for (k = 0; k < 20 && req_ready_out !== 1'b1; k++) @(negedge ref_clk_in);
    if (k == 20) begin
      n_mismatch++;
      test_done();
    end
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
    for (k = 0; k < 20 && rsp_valid_out !== 1'b1; k++) @(negedge ref_clk_in);
    if (k == 20) begin
      n_mismatch++;
      test_done();
    end
    if (!r.w) chk("read data", rsp_rdata_out, r.e);
    @(negedge ref_clk_in);
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {arst_n_in, req_valid_in, req_write_in, req_last_in, req_strict_in, byte_mode_in} = '0;
    {req_byte_en_in, req_addr_in, req_wdata_in} = '0;
    repeat (16) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    @(negedge ref_clk_in);
    foreach (rows[i]) acc(rows[i]);
    // Reset with a write request pending but not yet taken must park every strobe high
    {req_write_in, req_addr_in, req_byte_en_in, req_valid_in} = {1'b1, 18'h00008, 2'h3, 1'b1};
    repeat (3) @(negedge ref_clk_in);
    {arst_n_in, req_valid_in} = 2'b00;
    #1;
    chk("reset pins", {11'h000, mem_enable_n_out, mem_write_n_out, mem_output_n_out,
      mem_dq_oe_out, req_ready_out}, 16'h001c);
    @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    @(negedge ref_clk_in);
    chk("ready", {15'h0000, req_ready_out}, 16'h0001);
    acc(rows[3]);
    test_done();
  end
endmodule
